// *** core/icb_pkg.sv ***
// icb_pkg: shared constants and types of the i2c config block
// assumes: one 250 MHz cpu clock, 8-bit register data in low lane
package icb_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CFG_ADDR  = 8'hC8;
  localparam logic [7:0] CTL_ADDR  = 8'hCC;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int CFG_TEN    = 7;
  localparam int CFG_MRQ    = 6;
  localparam int CFG_CLR    = 5;
  localparam int CFG_RUN    = 4;
  localparam int CFG_SEL_HI = 1;
  localparam int CFG_SEL_LO = 0;
  localparam int CTL_ACK  = 0;
  localparam int CTL_STOP = 1;
  localparam int CTL_TX   = 2;
  localparam int STS_ATN  = 3;
  localparam int STS_OVF  = 4;
  localparam int STS_MST  = 5;
  localparam int STS_BUSY = 6;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // timing
  // ****************************************
  localparam int MC_CLKS = 6;
  localparam logic [3:0] MIN_REF    = 4'h8;
  localparam logic [2:0] MIN_CNT_00 = 3'h5;
  localparam logic [2:0] MIN_CNT_01 = 3'h6;
  localparam logic [2:0] MIN_CNT_10 = 3'h7;
  localparam logic [2:0] MIN_CNT_11 = 3'h4;
  localparam logic [10:0] TO_PER_00 = 11'h3FD;
  localparam logic [10:0] TO_PER_01 = 11'h3FE;
  localparam logic [10:0] TO_PER_10 = 11'h3FF;
  localparam logic [10:0] TO_PER_11 = 11'h3FC;
  // ****************************************
  // controller states
  // ****************************************
  typedef enum logic [7:0] {
    ST_IDLE      = 8'h01,
    ST_WAIT_STOP = 8'h02,
    ST_START     = 8'h04,
    ST_HOLD      = 8'h08,
    ST_LOW       = 8'h10,
    ST_HIGH      = 8'h20,
    ST_STOP_LOW  = 8'h40,
    ST_STOP_HIGH = 8'h80
  } icb_state_t;
endpackage

// *** core/icb_tmr_if.sv ***
// icb_tmr_if: link between controller and bus timer
// assumes: both ends on the same clock
`timescale 1ns/10ps
`default_nettype none
interface icb_tmr_if;
  logic       enable;
  logic       run;
  logic       frame;
  logic       reload;
  logic [1:0] sel;
  logic       min_done;
  logic       timeout;
  modport ctl (output enable, run, frame, reload, sel,
               input min_done, timeout);
  modport tmr (input enable, run, frame, reload, sel,
               output min_done, timeout);
endinterface
`default_nettype wire

// *** core/icb_bus_timer.sv ***
// icb_bus_timer: machine-cycle bus timer, min-time and hung-bus check
// assumes: controller drives reload on scl edges, start and stop
`timescale 1ns/10ps
`default_nettype none
module icb_bus_timer #(
  parameter int MC_CLKS = icb_pkg::MC_CLKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  icb_tmr_if.tmr   tif
);
  logic [2:0]  pre_reg, pre_next;
  logic [9:0]  cnt_reg, cnt_next;
  logic        done_reg, done_next;
  logic        to_reg, to_next;
  logic [2:0]  min_cnt;
  logic        tick;
  logic [11:0] since_reg;
  logic [10:0] ticks_reg;
  logic        skew_reg;
  logic [10:0] per;

  // ****************************************
  // count logic
  // ****************************************
  always_comb begin
    case (tif.sel)
      2'h0:    min_cnt = icb_pkg::MIN_CNT_00;
      2'h1:    min_cnt = icb_pkg::MIN_CNT_01;
      2'h2:    min_cnt = icb_pkg::MIN_CNT_10;
      default: min_cnt = icb_pkg::MIN_CNT_11;
    endcase
    tick      = (pre_reg == 3'(MC_CLKS - 1));
    pre_next  = tick ? 3'h0 : pre_reg + 3'h1;
    cnt_next  = cnt_reg;
    done_next = done_reg;
    to_next   = 1'b0;
    if (!tif.enable) begin
      pre_next  = 3'h0;
      cnt_next  = 10'h000;
      done_next = 1'b0;
    end else if (tif.reload) begin
      pre_next  = 3'h0;
      cnt_next  = 10'(icb_pkg::MIN_REF - {1'b0, min_cnt});
      done_next = 1'b0;
    end else if (!tif.run) begin
      cnt_next[9:3] = 7'h00;
      if (tick) begin
        cnt_next[2:0] = cnt_reg[2:0] + 3'h1;
        if (&cnt_reg[2:0])
          done_next = 1'b1;
      end
    end else if (tick && tif.frame) begin
      cnt_next = cnt_reg + 10'h001;
      if (&cnt_reg[2:0])
        done_next = 1'b1;
      if (&cnt_reg)
        to_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_reg  <= 3'h0;
      cnt_reg  <= 10'h000;
      done_reg <= 1'b0;
      to_reg   <= 1'b0;
    end else begin
      pre_reg  <= pre_next;
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
      to_reg   <= to_next;
    end
  end

  assign tif.min_done = done_reg;
  assign tif.timeout  = to_reg;

  // ****************************************
  // checks
  // ****************************************
  always_comb begin
    case (tif.sel)
      2'h0:    per = icb_pkg::TO_PER_00;
      2'h1:    per = icb_pkg::TO_PER_01;
      2'h2:    per = icb_pkg::TO_PER_10;
      default: per = icb_pkg::TO_PER_11;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || tif.reload) begin
      since_reg <= 12'h000;
      ticks_reg <= 11'h000;
    end else begin
      since_reg <= since_reg + 12'h001;
      if (tick && tif.enable && (!tif.run || tif.frame))
        ticks_reg <= ticks_reg + 11'h001;
    end
  end

  // count no longer started from the reload value
  always_ff @(posedge clk_i) begin
    if (rst_i)
      skew_reg <= 1'b1;
    else if (tif.reload)
      skew_reg <= 1'b0;
    else if (!tif.enable || (!tif.run
             && (|cnt_reg[9:3] || (tick && &cnt_reg[2:0]))))
      skew_reg <= 1'b1;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_DISABLED_CLEAR: assert property (
    !tif.enable |=> cnt_reg == 10'h000 && !done_reg)
    else $error("timer not cleared while disabled");
  AST_RUN0_UPPER_IDLE: assert property (
    tif.enable && !tif.run |=> cnt_reg[9:3] == 7'h00)
    else $error("upper timer bits moved with run low");
  AST_RELOAD_VAL: assert property (
    tif.enable && tif.reload && tif.sel == 2'h3 |=> cnt_reg == 10'h004)
    else $error("wrong reload value");
  AST_MIN_TIME: assert property (
    $rose(done_reg) && !tif.run |-> since_reg == 12'(MC_CLKS * min_cnt))
    else $error("minimum time length wrong");
  AST_TIMEOUT_PER: assert property (
    $rose(to_reg) && !skew_reg |-> ticks_reg == per)
    else $error("time-out period wrong");
  AST_RUN_COUNTS: assert property (
    tif.enable && tif.run && tif.frame && !tif.reload && tick
    |=> cnt_reg == $past(cnt_reg) + 10'h001)
    else $error("timer did not count in frame");
  COV_MIN_DONE: cover property ($rose(done_reg));
endmodule
`default_nettype wire

// *** core/icb_config_top.sv ***
// icb_config_top: i2c configuration, mastership and bus timer block
// assumes: axi4-lite master on MCLK_I, open-drain pads outside
//
// Function
// - writing request bit starts acquiring mastership
// - busy bus: wait for stop first
// - after gain: start, then data ready, attention
// - time-out clears mastership request bit
// - clear bit clears overflow, always reads zero
// - run bit one counts, zero clears upper bits, low three still count
// - select field sets scl high/low, start/stop times
// - all enables zero: disabled, timer cleared
// - enabled, run zero: only low three bits count
// - run one: count in frames, reload on edges
// - select codes map to counts 5,6,7,4
// - time-out periods 1021, 1022, 1023, 1020
// - reload with 8 minus count, eight means done
// - one count is six cpu clocks
// - target enable set by write, cleared by time-out
// - stretch scl low until data ready answered
// - transmit bit reaches sda only while scl low
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module icb_config_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              MCLK_I,
  input  wire logic              RST_I,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  input  wire logic [31:0]       S_AXI_WDATA_I,
  input  wire logic [3:0]        S_AXI_WSTRB_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  output logic [1:0]             S_AXI_BRESP_O,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  output logic [31:0]            S_AXI_RDATA_O,
  output logic [1:0]             S_AXI_RRESP_O,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  input  wire logic              SCL_I,
  output logic                   SCL_O,
  output logic                   SCL_OE_O,
  input  wire logic              SDA_I,
  output logic                   SDA_O,
  output logic                   SDA_OE_O,
  output logic                   ATTN_O,
  output logic                   TIMEOUT_O
);
  // ****************************************
  // declarations
  // ****************************************
  icb_tmr_if tif ();
  icb_pkg::icb_state_t state_reg, state_next;
  logic [1:0] sync1_reg, sync2_reg;
  logic scl_s, sda_s, scl_d_reg, sda_d_reg, start_det, stop_det;
  logic ten_reg, ten_next, mrq_reg, mrq_next, run_reg, run_next;
  logic [1:0] sel_reg, sel_next;
  logic data_ready_flag_reg, data_ready_flag_next, stop_reg, stop_next, tx_reg, tx_next;
  logic txs_reg, txs_next, ovf_reg, ovf_next, mst_reg, mst_next;
  logic busy_reg, busy_next, scl_oe_reg, scl_oe_next;
  logic sda_oe_reg, sda_oe_next, atn_reg, atn_next, to_reg;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic rvalid_reg, rvalid_next, rd_cfg_reg, rd_cfg_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [7:0] wdata_reg, wdata_next, cfg_rd, ctl_rd;
  logic wstrb_reg, wstrb_next, wr_commit, wr_cfg, wr_ctl;
  logic ar_cfg, ar_ctl;

  // ****************************************
  // pin sync and bus condition detect
  // ****************************************
  assign scl_s     = sync2_reg[1];
  assign sda_s     = sync2_reg[0];
  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      sync1_reg <= 2'h3;
      sync2_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      sync1_reg <= {SCL_I, SDA_I};
      sync2_reg <= sync1_reg;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // ****************************************
  // bus timer
  // ****************************************
  assign tif.enable = ten_reg || mrq_reg || mst_reg;
  assign tif.run    = run_reg;
  assign tif.frame  = busy_reg || mst_reg;
  assign tif.sel    = sel_reg;
  assign tif.reload = (scl_s != scl_d_reg) || start_det || stop_det
                      || (state_next != state_reg);

  icb_bus_timer #(.MC_CLKS(icb_pkg::MC_CLKS)) u_timer (
    .clk_i (MCLK_I),
    .rst_i (RST_I),
    .tif   (tif.tmr)
  );

  // ****************************************
  // register bus slave
  // ****************************************
  assign wr_commit = aw_have_reg && w_have_reg && !bvalid_reg;
  assign wr_cfg = wstrb_reg
                  && awaddr_reg[7:2] == icb_pkg::CFG_ADDR[7:2];
  assign wr_ctl = wstrb_reg
                  && awaddr_reg[7:2] == icb_pkg::CTL_ADDR[7:2];
  assign ar_cfg = S_AXI_ARADDR_I[7:2] == icb_pkg::CFG_ADDR[7:2];
  assign ar_ctl = S_AXI_ARADDR_I[7:2] == icb_pkg::CTL_ADDR[7:2];
  assign cfg_rd = {ten_reg, mrq_reg, 1'b0, run_reg, 2'h0, sel_reg};
  assign ctl_rd = {1'b0, busy_reg, mst_reg, ovf_reg, atn_reg,
                   tx_reg, stop_reg, data_ready_flag_reg};

  always_comb begin
    aw_have_next = aw_have_reg;
    awaddr_next  = awaddr_reg;
    w_have_next  = w_have_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg && !S_AXI_BREADY_I;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg && !S_AXI_RREADY_I;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    rd_cfg_next  = rd_cfg_reg;
    if (S_AXI_AWVALID_I && awready_reg) begin
      aw_have_next = 1'b1;
      awaddr_next  = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && wready_reg) begin
      w_have_next = 1'b1;
      wdata_next  = S_AXI_WDATA_I[7:0];
      wstrb_next  = S_AXI_WSTRB_I[0];
    end
    if (wr_commit) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = (awaddr_reg[7:2] == icb_pkg::CFG_ADDR[7:2]
                     || awaddr_reg[7:2] == icb_pkg::CTL_ADDR[7:2])
                     ? icb_pkg::RESP_OKAY : icb_pkg::RESP_SLVERR;
    end
    if (S_AXI_ARVALID_I && arready_reg) begin
      rvalid_next = 1'b1;
      rd_cfg_next = ar_cfg;
      rdata_next  = 32'h0000_0000;
      rresp_next  = icb_pkg::RESP_OKAY;
      if (ar_cfg)
        rdata_next = {24'h00_0000, cfg_rd};
      else if (ar_ctl)
        rdata_next = {24'h00_0000, ctl_rd};
      else
        rresp_next = icb_pkg::RESP_SLVERR;
    end
    awready_next = !aw_have_next;
    wready_next  = !w_have_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      aw_have_reg <= 1'b0;
      awaddr_reg  <= '0;
      w_have_reg  <= 1'b0;
      wdata_reg   <= 8'h00;
      wstrb_reg   <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= 2'h0;
      rd_cfg_reg  <= 1'b0;
    end else begin
      aw_have_reg <= aw_have_next;
      awaddr_reg  <= awaddr_next;
      w_have_reg  <= w_have_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      rd_cfg_reg  <= rd_cfg_next;
    end
  end

  // ****************************************
  // configuration and bus controller
  // ****************************************
  always_comb begin
    state_next  = state_reg;
    ten_next    = ten_reg;
    mrq_next    = mrq_reg;
    run_next    = run_reg;
    sel_next    = sel_reg;
    data_ready_flag_next   = data_ready_flag_reg;
    stop_next   = stop_reg;
    tx_next     = tx_reg;
    ovf_next    = ovf_reg;
    mst_next    = mst_reg;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    busy_next   = start_det ? 1'b1 : (stop_det ? 1'b0 : busy_reg);
    txs_next    = scl_s ? txs_reg : tx_reg;
    if (wr_commit && wr_cfg) begin
      ten_next = wdata_reg[icb_pkg::CFG_TEN];
      mrq_next = wdata_reg[icb_pkg::CFG_MRQ];
      run_next = wdata_reg[icb_pkg::CFG_RUN];
      sel_next = wdata_reg[icb_pkg::CFG_SEL_HI:icb_pkg::CFG_SEL_LO];
      if (wdata_reg[icb_pkg::CFG_CLR])
        ovf_next = 1'b0;
    end
    if (wr_commit && wr_ctl) begin
      if (wdata_reg[icb_pkg::CTL_ACK])
        data_ready_flag_next = 1'b0;
      if (wdata_reg[icb_pkg::CTL_STOP])
        stop_next = 1'b1;
      tx_next = wdata_reg[icb_pkg::CTL_TX];
    end
    case (state_reg)
      icb_pkg::ST_IDLE: begin
        if (mrq_reg && !mst_reg)
          state_next = busy_reg ? icb_pkg::ST_WAIT_STOP
                                : icb_pkg::ST_START;
      end
      icb_pkg::ST_WAIT_STOP: begin
        if (!mrq_reg)
          state_next = icb_pkg::ST_IDLE;
        else if (stop_det || !busy_reg)
          state_next = icb_pkg::ST_START;
      end
      icb_pkg::ST_START: begin
        sda_oe_next = 1'b1;
        if (tif.min_done && !scl_oe_reg) begin
          scl_oe_next = 1'b1;
          data_ready_flag_next   = 1'b1;
          mst_next    = 1'b1;
          state_next  = icb_pkg::ST_HOLD;
        end
      end
      icb_pkg::ST_HOLD: begin
        if (!data_ready_flag_reg)
          state_next = stop_reg ? icb_pkg::ST_STOP_LOW
                                : icb_pkg::ST_LOW;
      end
      icb_pkg::ST_LOW: begin
        sda_oe_next = !txs_reg;
        if (tif.min_done) begin
          scl_oe_next = 1'b0;
          state_next  = icb_pkg::ST_HIGH;
        end
      end
      icb_pkg::ST_HIGH: begin
        if (scl_s && scl_d_reg && tif.min_done) begin
          scl_oe_next = 1'b1;
          data_ready_flag_next   = 1'b1;
          state_next  = icb_pkg::ST_HOLD;
        end
      end
      icb_pkg::ST_STOP_LOW: begin
        sda_oe_next = 1'b1;
        if (tif.min_done) begin
          scl_oe_next = 1'b0;
          state_next  = icb_pkg::ST_STOP_HIGH;
        end
      end
      icb_pkg::ST_STOP_HIGH: begin
        if (scl_s && scl_d_reg && tif.min_done) begin
          sda_oe_next = 1'b0;
          stop_next   = 1'b0;
          mst_next    = 1'b0;
          mrq_next    = 1'b0;
          state_next  = icb_pkg::ST_IDLE;
        end
      end
      default: state_next = icb_pkg::ST_IDLE;
    endcase
    if (tif.timeout) begin
      ovf_next    = 1'b1;
      ten_next    = 1'b0;
      mrq_next    = 1'b0;
      mst_next    = 1'b0;
      stop_next   = 1'b0;
      busy_next   = 1'b0;
      scl_oe_next = 1'b0;
      sda_oe_next = 1'b0;
      state_next  = icb_pkg::ST_IDLE;
    end
    atn_next = data_ready_flag_next || ovf_next;
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      state_reg  <= icb_pkg::ST_IDLE;
      ten_reg    <= icb_pkg::CFG_RESET[icb_pkg::CFG_TEN];
      mrq_reg    <= icb_pkg::CFG_RESET[icb_pkg::CFG_MRQ];
      run_reg    <= icb_pkg::CFG_RESET[icb_pkg::CFG_RUN];
      sel_reg    <= icb_pkg::CFG_RESET[1:0];
      data_ready_flag_reg   <= 1'b0;
      stop_reg   <= 1'b0;
      tx_reg     <= 1'b1;
      txs_reg    <= 1'b1;
      ovf_reg    <= 1'b0;
      mst_reg    <= 1'b0;
      busy_reg   <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      atn_reg    <= 1'b0;
      to_reg     <= 1'b0;
    end else begin
      state_reg  <= state_next;
      ten_reg    <= ten_next;
      mrq_reg    <= mrq_next;
      run_reg    <= run_next;
      sel_reg    <= sel_next;
      data_ready_flag_reg   <= data_ready_flag_next;
      stop_reg   <= stop_next;
      tx_reg     <= tx_next;
      txs_reg    <= txs_next;
      ovf_reg    <= ovf_next;
      mst_reg    <= mst_next;
      busy_reg   <= busy_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      atn_reg    <= atn_next;
      to_reg     <= tif.timeout;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign S_AXI_AWREADY_O = awready_reg;
  assign S_AXI_WREADY_O  = wready_reg;
  assign S_AXI_BVALID_O  = bvalid_reg;
  assign S_AXI_BRESP_O   = bresp_reg;
  assign S_AXI_ARREADY_O = arready_reg;
  assign S_AXI_RVALID_O  = rvalid_reg;
  assign S_AXI_RDATA_O   = rdata_reg;
  assign S_AXI_RRESP_O   = rresp_reg;
  assign SCL_O           = 1'b0;
  assign SDA_O           = 1'b0;
  assign SCL_OE_O        = scl_oe_reg;
  assign SDA_OE_O        = sda_oe_reg;
  assign ATTN_O          = atn_reg;
  assign TIMEOUT_O       = to_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  AST_REQ_START: assert property (
    state_reg == icb_pkg::ST_IDLE && mrq_reg && !mst_reg && !busy_reg
    && !tif.timeout |=> state_reg == icb_pkg::ST_START)
    else $error("request did not start acquisition");
  AST_WAIT_STOP: assert property (
    state_reg == icb_pkg::ST_WAIT_STOP && mrq_reg && busy_reg
    && !stop_det && !tif.timeout |=> state_reg == icb_pkg::ST_WAIT_STOP)
    else $error("left wait before stop");
  AST_START_DATA_READY_FLAG: assert property (
    state_reg == icb_pkg::ST_START && tif.min_done && !scl_oe_reg
    && !tif.timeout |=> data_ready_flag_reg ##1 ATTN_O)
    else $error("no data ready after start");
  AST_TO_MRQ: assert property (
    tif.timeout |=> !mrq_reg && state_reg == icb_pkg::ST_IDLE)
    else $error("request kept after time-out");
  AST_CLR_READ0: assert property (
    S_AXI_RVALID_O && rd_cfg_reg |-> !S_AXI_RDATA_O[icb_pkg::CFG_CLR])
    else $error("clear bit read as one");
  AST_CLR_OVF: assert property (
    wr_commit && wr_cfg && wdata_reg[icb_pkg::CFG_CLR] && !tif.timeout
    |=> !ovf_reg)
    else $error("overflow flag not cleared");
  AST_TO_TEN: assert property (
    tif.timeout |=> !ten_reg ##1 TIMEOUT_O == 1'b0)
    else $error("target enable kept after time-out");
  AST_TO_OVF: assert property (
    tif.timeout |=> ovf_reg && TIMEOUT_O)
    else $error("overflow not flagged on time-out");
  AST_STRETCH: assert property (
    state_reg == icb_pkg::ST_HOLD && data_ready_flag_reg && !tif.timeout
    |=> SCL_OE_O)
    else $error("scl released before answer");
  AST_TX_LOW: assert property (
    txs_reg != $past(txs_reg) |-> !$past(scl_s))
    else $error("data changed while scl high");
  AST_LOW_MIN: assert property (
    state_reg == icb_pkg::ST_LOW && !tif.min_done && !tif.timeout
    |=> state_reg == icb_pkg::ST_LOW && SCL_OE_O)
    else $error("scl low phase cut short");
  COV_HOLD: cover property (state_reg == icb_pkg::ST_HOLD);
  COV_STOP: cover property (state_reg == icb_pkg::ST_STOP_HIGH
                            ##1 state_reg == icb_pkg::ST_IDLE);
  COV_TO: cover property (tif.timeout);
endmodule
`default_nettype wire

// *** tb/icb_i2c_peer.sv ***
// icb_i2c_peer: open-drain bus with pull-ups and a second controller
// assumes: hold_sda_i high while scl idles high means start, release stop
`timescale 1ns/10ps
`default_nettype none
module icb_i2c_peer (
  input  wire logic scl_oe_i,
  input  wire logic sda_oe_i,
  input  wire logic hold_sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // ****************************************
  // wired-and lines, pulled up
  // ****************************************
  assign scl_o = !scl_oe_i;
  assign sda_o = !(sda_oe_i || hold_sda_i);
endmodule
`default_nettype wire

// *** tb/icb_config_top_bench.sv ***
// icb_config_top_bench: register, mastership and time-out tests
// assumes: icb_i2c_peer stands for the far side of the bus
`timescale 1ns/10ps
`default_nettype none
module icb_config_top_bench;
  logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0;
  logic        bre = 1'b0, arv = 1'b0, rre = 1'b0, hold = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, rdo;
  logic [1:0]  rr, br, brs, rrs;
  logic        awr, wrd, bv, arr, rv, scl, sda, scl_oe, sda_oe, attn, tmo;
  logic        scl_o, sda_o;
  int          err_total = 0, check_count = 0, cyc = 0, n;
  // ****************************************
  // clock, watchdog, bus tasks
  // ****************************************
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      finish_test;
    end
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    br = brs;
    bre <= 1'b0;
  endtask
  task automatic rd_(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rd = rdo;
    rr = rrs;
    rre <= 1'b0;
  endtask
  task automatic wt(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_(8'hC8);
    chk("cfg_reset", rd, 32'h0);
    rd_(8'hD0);
    chk("unmapped", 32'(rr), 32'(icb_pkg::RESP_SLVERR));
    wr(8'hD0, 32'hFF);
    chk("bresp_unmapped", 32'(br), 32'(icb_pkg::RESP_SLVERR));
    wr(8'hC8, 32'hB3);
    chk("bresp_cfg", 32'(br), 32'(icb_pkg::RESP_OKAY));
    rd_(8'hC8);
    chk("cfg_bits", rd, 32'h93);
    chk("pads", 32'({scl_o, sda_o}), 32'h0);
    wr(8'hC8, 32'h02);
    hold <= 1'b1;
    wr(8'hC8, 32'h42);
    repeat (40) @(posedge clk);
    chk("wait_stop", 32'(sda_oe), 32'h0);
    hold <= 1'b0;
    wt(sda_oe, 60);
    chk("start", 32'(sda_oe), 32'h1);
    wt(scl_oe, 200);
    chk("min_time", 32'(n >= 42), 32'h1);
    wt(attn, 10);
    chk("attention", 32'(attn), 32'h1);
    wr(8'hC8, 32'h52);
    repeat (500) @(posedge clk);
    chk("stretch", 32'(scl_oe), 32'h1);
    wt(tmo, 7000);
    chk("timeout", 32'(tmo), 32'h1);
    rd_(8'hC8);
    chk("cfg_after_to", rd, 32'h12);
    rd_(8'hCC);
    chk("ovf_set", 32'(rd[icb_pkg::STS_OVF]), 32'h1);
    wr(8'hC8, 32'h32);
    rd_(8'hCC);
    chk("ovf_clr", 32'(rd[icb_pkg::STS_OVF]), 32'h0);
    wr(8'hCC, 32'h05);
    wr(8'hC8, 32'h43);
    wt(attn, 200);
    chk("attn_sel3", 32'(attn), 32'h1);
    wr(8'hCC, 32'h07);
    repeat (200) @(posedge clk);
    rd_(8'hC8);
    chk("mrq_after_stop", rd, 32'h03);
    rd_(8'hCC);
    chk("mst_after_stop", 32'(rd[icb_pkg::STS_MST]), 32'h0);
    chk("lines_free", 32'({scl_oe, sda_oe}), 32'h0);
    wr(8'hC8, 32'h00);
    rd_(8'hC8);
    chk("cfg_off", rd, 32'h0);
    finish_test;
  end
  icb_i2c_peer peer (.scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
    .hold_sda_i(hold), .scl_o(scl), .sda_o(sda));
  icb_config_top dut (.MCLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awa),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd),
    .S_AXI_BRESP_O(brs), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdo), .S_AXI_RRESP_O(rrs), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rre), .SCL_I(scl), .SCL_O(scl_o), .SCL_OE_O(scl_oe),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .ATTN_O(attn),
    .TIMEOUT_O(tmo));
endmodule
`default_nettype wire
